// ===== logic/cpsm_mux.sv
// status pin mux: loads configuration, drives four configurable pins
// assumes usb/uart core signals are on clk_sys_in; pins arrive async
`timescale 1ns/100ps
module cpsm_mux #(
    parameter int CFG_WORDS = 64,
    parameter int WAKE_CYC = cpsm_pkg::WAKE_TIME_MS * cpsm_pkg::CLK_PER_MS,
    parameter int LED_CYC = cpsm_pkg::LED_TIME_MS * cpsm_pkg::CLK_PER_MS
) (
    input logic clk_sys_in,
    input logic reset_n_in,
    input logic usb_reset_in,
    input logic suspend_in,
    input logic charge_port_in,
    input logic up_active_in,
    input logic dn_active_in,
    input logic tx_char_ready_in,
    input logic bit_tick_in,
    input logic tx_stop_in,
    input logic txd_core_in,
    input logic rts_core_in,
    input logic rxd_pin_in,
    input logic cts_pin_in,
    input logic ring_indicate_n_in,
    input logic cfg_valid_in,
    input logic [15:0] cfg_data_in,
    input logic [3:0] avs_address_in,
    input logic avs_read_in,
    input logic avs_write_in,
    input logic [31:0] avs_writedata_in,
    input logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic cfg_rd_out,
    output logic [9:0] cfg_addr_out,
    output logic [3:0] cfg_pin_out,
    output logic [3:0] cfg_pin_oe_out,
    output logic txd_pin_out,
    output logic rts_pin_out,
    output logic rxd_core_out,
    output logic cts_core_out,
    output logic uart_pulldown_out,
    output logic remote_wake_out,
    output logic tx_go_out,
    output logic config_loaded_out,
    output logic [15:0] usb_version_out,
    output logic [7:0] max_power_out,
    output logic self_powered_out,
    output logic serial_en_out
);
    // ==========================================
    // state
    cpsm_pkg::cpsm_cfg_t cfg_ff;
    cpsm_pkg::cpsm_ld_t ld_ff;
    cpsm_pkg::cpsm_de_t de_ff;
    logic [31:0] led_cnt_ff [3];
    logic [2:0] led_on;
    logic [2:0] act;
    logic [31:0] wake_cnt_ff;
    logic [2:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;
    logic wait_ff, wr_ok, reload;
    logic [3:0] nxt_pin, nxt_oe;

    assign wr_ok = avs_write_in && !wait_ff;
    assign reload = wr_ok && avs_address_in == cpsm_pkg::ADDR_CTRL
        && avs_byteenable_in[0] && avs_writedata_in[cpsm_pkg::CTRL_RELOAD_BIT];

    function automatic logic [15:0] be_merge(input logic [15:0] old,
            input logic [31:0] wd, input logic [3:0] be);
        be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ==========================================
    // bus slave: one wait cycle, then answer
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((avs_read_in || avs_write_in) && wait_ff);
        end
    end

    // read data latched as waitrequest drops; unmapped reads give zero
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && wait_ff) begin
            unique case (avs_address_in)
                cpsm_pkg::ADDR_STATUS: avs_readdata_out <= {24'h00_0000,
                    de_ff == cpsm_pkg::DE_SEND, led_on, remote_wake_out,
                    charge_port_in, suspend_in, config_loaded_out};
                cpsm_pkg::ADDR_PIN_SEL: avs_readdata_out <= {16'h0000, cfg_ff.sel};
                cpsm_pkg::ADDR_OPTIONS: avs_readdata_out <= {16'h0000, cfg_ff.opt};
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_waitrequest_out = wait_ff;

    // ==========================================
    // configuration load; bus writes may override after
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || usb_reset_in || reload) begin
            ld_ff <= cpsm_pkg::LD_REQ;
            cfg_addr_out <= 10'h000;
            cfg_rd_out <= 1'b0;
        end else begin
            cfg_rd_out <= 1'b0;
            unique case (ld_ff)
                cpsm_pkg::LD_REQ: begin
                    cfg_rd_out <= 1'b1;
                    ld_ff <= cpsm_pkg::LD_WAIT;
                end
                cpsm_pkg::LD_WAIT: begin
                    if (cfg_valid_in) begin
                        if (cfg_addr_out == 10'(CFG_WORDS - 1)) begin
                            ld_ff <= cpsm_pkg::LD_RUN;
                        end else begin
                            cfg_addr_out <= cfg_addr_out + 10'h001;
                            ld_ff <= cpsm_pkg::LD_REQ;
                        end
                    end
                end
                cpsm_pkg::LD_RUN: ld_ff <= cpsm_pkg::LD_RUN;
                default: ld_ff <= cpsm_pkg::LD_REQ;
            endcase
        end
    end

    // factory defaults until memory words arrive
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cfg_ff <= cpsm_pkg::RST_CFG;
        end else if (ld_ff == cpsm_pkg::LD_WAIT && cfg_valid_in) begin
            if (cfg_addr_out == cpsm_pkg::CFG_ADDR_SEL) begin
                cfg_ff.sel <= cpsm_pkg::cpsm_sel_t'(cfg_data_in);
            end
            if (cfg_addr_out == cpsm_pkg::CFG_ADDR_OPT) begin
                cfg_ff.opt <= cpsm_pkg::cpsm_opt_t'(cfg_data_in);
            end
        end else if (wr_ok && avs_address_in == cpsm_pkg::ADDR_PIN_SEL) begin
            cfg_ff.sel <= cpsm_pkg::cpsm_sel_t'(be_merge(cfg_ff.sel,
                avs_writedata_in, avs_byteenable_in));
        end else if (wr_ok && avs_address_in == cpsm_pkg::ADDR_OPTIONS) begin
            cfg_ff.opt <= cpsm_pkg::cpsm_opt_t'(be_merge(cfg_ff.opt,
                avs_writedata_in, avs_byteenable_in));
        end
    end

    // descriptor fields handed to the usb engine
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            config_loaded_out <= 1'b0;
            usb_version_out <= 16'h0000;
            max_power_out <= 8'h00;
            self_powered_out <= 1'b0;
            serial_en_out <= 1'b0;
        end else begin
            config_loaded_out <= ld_ff == cpsm_pkg::LD_RUN;
            usb_version_out <= cpsm_pkg::USB_BCD;
            max_power_out <= cfg_ff.opt.max_power;
            self_powered_out <= cfg_ff.opt.self_pwr;
            serial_en_out <= cfg_ff.opt.serial_en;
        end
    end

    // ==========================================
    // pin synchronisers: rxd, cts, ring; change accepted on 2nd/3rd agree
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sync1_ff <= 3'h7;
            sync2_ff <= 3'h7;
            sync3_ff <= 3'h7;
            filt_ff <= 3'h7;
        end else begin
            sync1_ff <= {ring_indicate_n_in, cts_pin_in, rxd_pin_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            filt_ff <= (filt_ff & (sync2_ff ^ sync3_ff)) | (sync2_ff & sync3_ff);
        end
    end

    // ==========================================
    // uart line polarity
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            txd_pin_out <= 1'b1;
            rts_pin_out <= 1'b1;
            rxd_core_out <= 1'b1;
            cts_core_out <= 1'b1;
        end else begin
            txd_pin_out <= txd_core_in ^ cfg_ff.opt.inv_txd;
            rxd_core_out <= filt_ff[0] ^ cfg_ff.opt.inv_rxd;
            rts_pin_out <= rts_core_in ^ cfg_ff.opt.inv_rts;
            cts_core_out <= filt_ff[1] ^ cfg_ff.opt.inv_cts;
        end
    end

    // pull-down only while suspended, i.e. while power enable is high
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            uart_pulldown_out <= 1'b0;
        end else begin
            uart_pulldown_out <= config_loaded_out && suspend_in
                && cfg_ff.opt.pd_susp;
        end
    end

    // ==========================================
    // remote wake: ring held low for the wake time while suspended
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            wake_cnt_ff <= 32'h0000_0000;
            remote_wake_out <= 1'b0;
        end else if (!suspend_in || !cfg_ff.opt.rwake_en) begin
            wake_cnt_ff <= 32'h0000_0000;
            remote_wake_out <= 1'b0;
        end else if (!filt_ff[2]) begin
            if (wake_cnt_ff == 32'(WAKE_CYC - 1)) begin
                remote_wake_out <= 1'b1;
            end else begin
                wake_cnt_ff <= wake_cnt_ff + 32'h0000_0001;
            end
        end else begin
            wake_cnt_ff <= 32'h0000_0000;
        end
    end

    // ==========================================
    // rs485 line enable: lead by one bit tick, drop with stop bit
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in || !config_loaded_out) begin
            de_ff <= cpsm_pkg::DE_IDLE;
            tx_go_out <= 1'b0;
        end else begin
            tx_go_out <= 1'b0;
            unique case (de_ff)
                cpsm_pkg::DE_IDLE: begin
                    if (tx_char_ready_in) begin
                        de_ff <= cpsm_pkg::DE_LEAD;
                    end
                end
                cpsm_pkg::DE_LEAD: begin
                    if (bit_tick_in) begin
                        tx_go_out <= 1'b1;
                        de_ff <= cpsm_pkg::DE_SEND;
                    end
                end
                cpsm_pkg::DE_SEND: begin
                    if (tx_stop_in) begin
                        de_ff <= cpsm_pkg::DE_IDLE;
                    end
                end
                default: de_ff <= cpsm_pkg::DE_IDLE;
            endcase
        end
    end

    // ==========================================
    // activity one-shots: up, down, either
    assign act = {up_active_in || dn_active_in, dn_active_in, up_active_in};
    for (genvar i = 0; i < 3; i++) begin : g_led
        // retrigger reloads the full time so sparse bytes stay visible
        always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) begin
                led_cnt_ff[i] <= 32'h0000_0000;
            end else if (act[i]) begin
                led_cnt_ff[i] <= 32'(LED_CYC);
            end else if (led_cnt_ff[i] != 32'h0000_0000) begin
                led_cnt_ff[i] <= led_cnt_ff[i] - 32'h0000_0001;
            end
        end
        assign led_on[i] = led_cnt_ff[i] != 32'h0000_0000;
    end

    // ==========================================
    // pin function mux
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            nxt_pin[p] = 1'b0;
            nxt_oe[p] = 1'b1;
            unique case (cfg_ff.sel[p])
                cpsm_pkg::FN_DRV_EN: nxt_pin[p] = de_ff != cpsm_pkg::DE_IDLE;
                cpsm_pkg::FN_UP_LED: nxt_oe[p] = led_on[0];
                cpsm_pkg::FN_DN_LED: nxt_oe[p] = led_on[1];
                cpsm_pkg::FN_ANY_LED: nxt_oe[p] = led_on[2];
                cpsm_pkg::FN_SLEEP_N: nxt_pin[p] = !suspend_in;
                cpsm_pkg::FN_POWER_ENABLE_N: nxt_pin[p] = suspend_in;
                cpsm_pkg::FN_CHG: nxt_pin[p] = suspend_in && charge_port_in;
                cpsm_pkg::FN_CHG_N: nxt_pin[p] = !(suspend_in && charge_port_in);
                default: nxt_oe[p] = 1'b0;
            endcase
            if (!config_loaded_out) begin
                nxt_oe[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cfg_pin_out <= 4'h0;
            cfg_pin_oe_out <= 4'h0;
        end else begin
            cfg_pin_out <= nxt_pin;
            cfg_pin_oe_out <= nxt_oe;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_lead;
        de_ff == cpsm_pkg::DE_LEAD && bit_tick_in;
    endsequence
    sequence s_send;
        tx_go_out && de_ff == cpsm_pkg::DE_SEND ##1 !tx_go_out;
    endsequence

    chg_set_a: assert property (
        config_loaded_out && suspend_in && charge_port_in
        && cfg_ff.sel[1] == cpsm_pkg::FN_CHG |=> cfg_pin_out[1] && cfg_pin_oe_out[1])
        else $error("charger output not raised");
    chg_quiet_a: assert property (
        config_loaded_out && !suspend_in && cfg_ff.sel[1] == cpsm_pkg::FN_CHG
        |=> !cfg_pin_out[1]) else $error("charger output active when awake");
    led_drive_a: assert property (
        config_loaded_out && cfg_ff.sel[1] == cpsm_pkg::FN_DN_LED && dn_active_in
        && $stable(cfg_ff.sel) ##1 config_loaded_out && $stable(cfg_ff.sel)
        |=> cfg_pin_oe_out[1] && !cfg_pin_out[1]) else $error("led not driven low");
    led_hold_a: assert property (
        up_active_in |=> led_cnt_ff[0] == 32'(LED_CYC)) else $error("one-shot not loaded");
    load_float_a: assert property (
        !config_loaded_out |=> cfg_pin_oe_out == 4'h0) else $error("pin driven before load");
    reload_a: assert property (
        usb_reset_in |=> ld_ff == cpsm_pkg::LD_REQ ##1 !config_loaded_out)
        else $error("bus reset did not reload");
    line_lead_a: assert property (
        s_lead |=> s_send) else $error("start not released after lead bit");
    line_stop_a: assert property (
        de_ff == cpsm_pkg::DE_SEND && tx_stop_in |=> de_ff == cpsm_pkg::DE_IDLE)
        else $error("line enable kept past stop bit");
    sleep_pin_a: assert property (
        config_loaded_out && cfg_ff.sel[3] == cpsm_pkg::FN_SLEEP_N
        |=> cfg_pin_oe_out[3] && cfg_pin_out[3] == !$past(suspend_in))
        else $error("sleep pin wrong");
    pull_down_a: assert property (
        !suspend_in |=> !uart_pulldown_out) else $error("pull-down while awake");
    wake_cause_a: assert property (
        $rose(remote_wake_out) |-> $past(suspend_in) && $past(cfg_ff.opt.rwake_en)
        && wake_cnt_ff == 32'(WAKE_CYC - 1)) else $error("wake without cause");
    txd_inv_a: assert property (
        ##1 txd_pin_out == ($past(txd_core_in) ^ $past(cfg_ff.opt.inv_txd)))
        else $error("txd polarity wrong");
endmodule

// ===== logic/cpsm_pkg.sv
// package for the configurable status pin mux of a usb-uart bridge
// assumes one 100 MHz system clock and a 16-bit configuration memory
package cpsm_pkg;
    // ==========================================
    // pin functions
    typedef enum logic [3:0] {
        FN_DRV_EN = 4'h0,
        FN_DN_LED = 4'h1,
        FN_UP_LED = 4'h2,
        FN_ANY_LED = 4'h3,
        FN_SLEEP_N = 4'h4,
        FN_POWER_ENABLE_N = 4'h5,
        FN_CHG = 4'h6,
        FN_CHG_N = 4'h7,
        FN_TRISTATE = 4'h8
    } cpsm_fn_t;
    // ==========================================
    // configuration words
    typedef struct packed {
        logic [7:0] max_power;
        logic self_pwr;
        logic serial_en;
        logic rwake_en;
        logic pd_susp;
        logic inv_cts;
        logic inv_rts;
        logic inv_rxd;
        logic inv_txd;
    } cpsm_opt_t;
    // one function code per pin, pin 0 in the low nibble
    typedef cpsm_fn_t [3:0] cpsm_sel_t;
    typedef struct packed {
        cpsm_sel_t sel;
        cpsm_opt_t opt;
    } cpsm_cfg_t;
    // pin3..0 sleep, up led, down led, driver enable; serial on, 90 mA
    localparam cpsm_cfg_t RST_CFG = cpsm_cfg_t'(32'h4210_2D40);
    localparam logic [15:0] USB_BCD = 16'h0200;
    localparam logic [9:0] CFG_ADDR_SEL = 10'h000;
    localparam logic [9:0] CFG_ADDR_OPT = 10'h001;
    // ==========================================
    // register map (byte addresses)
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_PIN_SEL = 4'h4;
    localparam logic [3:0] ADDR_OPTIONS = 4'h8;
    localparam logic [3:0] ADDR_CTRL = 4'hC;
    localparam int CTRL_RELOAD_BIT = 0;
    // ==========================================
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;
    localparam int WAKE_TIME_MS = 20;
    localparam int LED_TIME_MS = 10;
    // ==========================================
    // state machines
    typedef enum logic [1:0] {
        LD_REQ = 2'h0,
        LD_WAIT = 2'h1,
        LD_RUN = 2'h3
    } cpsm_ld_t;
    typedef enum logic [1:0] {
        DE_IDLE = 2'h0,
        DE_LEAD = 2'h1,
        DE_SEND = 2'h3
    } cpsm_de_t;
endpackage

// ===== verif/cpsm_mem_model.sv
// behavioural model of the nonvolatile configuration memory
// assumes word 0 holds pin select and word 1 options; reads come one at a time
`timescale 1ns/100ps
module cpsm_mem_model #(
    parameter int LAT = 3
) (
    input logic clk_sys_in,
    input logic reset_n_in,
    input logic rd_in,
    input logic [9:0] addr_in,
    input logic [15:0] sel_word_in,
    input logic [15:0] opt_word_in,
    output logic valid_out,
    output logic [15:0] data_out
);
    int cnt_ff;
    logic [9:0] addr_ff;
    // ==========================================
    // answer each word read after LAT cycles
    always @(posedge clk_sys_in) begin
        valid_out <= 1'b0;
        data_out <= ~data_out; // idle bus keeps changing, never a stale word
        if (!reset_n_in) begin
            cnt_ff <= 0;
            data_out <= 16'h5A5A;
        end else if (rd_in) begin
            cnt_ff <= LAT;
            addr_ff <= addr_in;
        end else if (cnt_ff == 1) begin
            cnt_ff <= 0;
            valid_out <= 1'b1;
            data_out <= (addr_ff == 10'h000) ? sel_word_in :
                (addr_ff == 10'h001) ? opt_word_in : {6'h00, addr_ff};
        end else if (cnt_ff > 1) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
endmodule

// ===== verif/tb_config_pin_status_signal_mux.sv
// self-checking bench for the status pin mux
// assumes pulled-up pins and a memory holding the factory defaults
`timescale 1ns/100ps
module tb_config_pin_status_signal_mux;
    localparam int LED_CYC = 20;
    localparam int WAKE_CYC = 30;
    // one-cycle strobes share one vector so a single task can pulse any of them
    localparam logic [4:0] P_DN = 5'h01;
    localparam logic [4:0] P_UP = 5'h02;
    localparam logic [4:0] P_TICK = 5'h04;
    localparam logic [4:0] P_STOP = 5'h08;
    localparam logic [4:0] P_RST = 5'h10;
    logic [4:0] pls;
    logic clk_sys_in, reset_n_in, usb_rst, susp, chg, up_act, dn_act, rdy, tick, stop;
    logic txd_c, rts_c, rxd_p, cts_p, ring_n, cfg_valid, cfg_rd, rd, wr, wreq, loaded, go;
    logic txd_p, rts_p, rxd_c, cts_c, pulld, wake, selfp, sern;
    logic [3:0] addr, pin, oe, pin_lvl;
    logic [31:0] wdata, rdata, got;
    logic [15:0] cfg_data, ver;
    logic [9:0] cfg_addr;
    logic [7:0] maxp;
    int bad_count, checks;
    // floating pins read high through the led pull-ups
    assign pin_lvl = (oe & pin) | ~oe;
    assign {usb_rst, stop, tick, up_act, dn_act} = pls;
    cpsm_mux #(.CFG_WORDS(4), .WAKE_CYC(WAKE_CYC), .LED_CYC(LED_CYC)) dut_u (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .usb_reset_in(usb_rst),
        .suspend_in(susp), .charge_port_in(chg), .up_active_in(up_act),
        .dn_active_in(dn_act), .tx_char_ready_in(rdy), .bit_tick_in(tick),
        .tx_stop_in(stop), .txd_core_in(txd_c), .rts_core_in(rts_c), .rxd_pin_in(rxd_p),
        .cts_pin_in(cts_p), .ring_indicate_n_in(ring_n), .cfg_valid_in(cfg_valid),
        .cfg_data_in(cfg_data), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .cfg_rd_out(cfg_rd),
        .cfg_addr_out(cfg_addr), .cfg_pin_out(pin), .cfg_pin_oe_out(oe),
        .txd_pin_out(txd_p), .rts_pin_out(rts_p), .rxd_core_out(rxd_c),
        .cts_core_out(cts_c), .uart_pulldown_out(pulld), .remote_wake_out(wake),
        .tx_go_out(go), .config_loaded_out(loaded), .usb_version_out(ver),
        .max_power_out(maxp), .self_powered_out(selfp), .serial_en_out(sern));
    // memory holds factory defaults: pins enable/down/up/sleep, 90 mA, serial on
    cpsm_mem_model #(.LAT(3)) mem_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .rd_in(cfg_rd), .addr_in(cfg_addr), .sel_word_in(16'h4210),
        .opt_word_in(16'h2D40), .valid_out(cfg_valid), .data_out(cfg_data));
    // ==========================================
    // clock and helpers
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task done(input string m);
        $display("test %s finished", m);
    endtask
    // one avalon access; holds the request until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "bus stall");
    endtask
    task pulse(input logic [4:0] m);
        @(posedge clk_sys_in);
        pls <= m;
        @(posedge clk_sys_in);
        pls <= 5'h00;
    endtask
    task wait_loaded();
        int n;
        n = 0;
        while (loaded !== 1'b1 && n < 200) begin
            tk(1);
            n++;
        end
        chk({31'h0, loaded}, 32'h1, "config load");
    endtask
    task final_report();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog: the tests need a few hundred cycles
    initial begin
        tk(20000);
        bad_count++;
        final_report();
    end
    // ==========================================
    // main sequence
    initial begin
        {susp, chg, rdy, rd, wr} = '0;
        pls = 5'h00;
        {txd_c, rts_c, rxd_p, cts_p, ring_n} = 5'h1D;
        addr = 4'h0;
        wdata = 32'h0;
        bad_count = 0;
        checks = 0;
        reset_n_in = 1'b0;
        tk(5);
        reset_n_in <= 1'b1;
        chk({28'h0, oe}, 32'h0, "pins float before load");
        wait_loaded();
        tk(2);
        chk({28'h0, oe}, 32'h9, "default drives");
        chk({28'h0, pin_lvl}, 32'hE, "default levels");
        chk({16'h0, ver}, 32'h200, "usb version");
        chk({22'h0, maxp, selfp, sern}, 32'hB5, "power and serial");
        chk({29'h0, pulld, txd_p, rts_p}, 32'h3, "uart defaults");
        bus(1'b0, cpsm_pkg::ADDR_OPTIONS, 32'h0);
        chk(got, 32'h2D40, "options read");
        bus(1'b0, cpsm_pkg::ADDR_PIN_SEL, 32'h0);
        chk(got, 32'h4210, "pin select read");
        bus(1'b0, cpsm_pkg::ADDR_STATUS, 32'h0);
        chk(got, 32'h1, "status idle");
        bus(1'b0, 4'h6, 32'h0);
        chk(got, 32'h0, "unmapped read");
        done("defaults");
        // led one-shot with retrigger
        pulse(P_DN);
        tk(4);
        chk({28'h0, pin_lvl & 4'h6, oe & 4'h6}, 32'h42, "down led on");
        pulse(P_DN);
        tk(LED_CYC - 4);
        chk({31'h0, oe[1]}, 32'h1, "down led stretched");
        tk(8);
        chk({31'h0, oe[1]}, 32'h0, "down led off");
        pulse(P_UP);
        tk(4);
        chk({28'h0, pin_lvl & 4'h6, oe & 4'h6}, 32'h24, "up led on");
        tk(LED_CYC + 4);
        done("leds");
        // sleep indicator
        susp <= 1'b1;
        tk(4);
        chk({31'h0, pin_lvl[3]}, 32'h0, "sleep low");
        susp <= 1'b0;
        tk(4);
        chk({31'h0, pin_lvl[3]}, 32'h1, "sleep high");
        done("sleep");
        // charger both polarities, power enable, combined led
        bus(1'b1, cpsm_pkg::ADDR_PIN_SEL, 32'h5763);
        susp <= 1'b1;
        chg <= 1'b1;
        tk(4);
        chk({28'h0, pin_lvl, oe}, 32'hBE, "charger in suspend");
        susp <= 1'b0;
        tk(4);
        chk({28'h0, pin_lvl, oe}, 32'h5E, "charger enumerated");
        pulse(P_UP);
        tk(4);
        chk({31'h0, pin_lvl[0]}, 32'h0, "any led up");
        tk(LED_CYC + 4);
        chk({31'h0, oe[0]}, 32'h0, "any led off");
        pulse(P_DN);
        tk(4);
        chk({31'h0, pin_lvl[0]}, 32'h0, "any led down");
        chg <= 1'b0;
        done("charger");
        // inversions, pull-down and remote wake
        bus(1'b1, cpsm_pkg::ADDR_OPTIONS, 32'h2D3F);
        rts_c <= 1'b0;
        cts_p <= 1'b0;
        tk(8);
        chk({28'h0, txd_p, rts_p, rxd_c, cts_c}, 32'h5, "inverted lines");
        susp <= 1'b1;
        ring_n <= 1'b0;
        tk(10);
        chk({30'h0, pulld, wake}, 32'h2, "suspend pulls, no wake yet");
        tk(WAKE_CYC + 5);
        chk({31'h0, wake}, 32'h1, "remote wake");
        susp <= 1'b0;
        ring_n <= 1'b1;
        tk(4);
        chk({31'h0, pulld}, 32'h0, "pull-down released");
        done("options");
        // reload restores memory contents and floats pins meanwhile
        bus(1'b1, cpsm_pkg::ADDR_CTRL, 32'h1);
        tk(3);
        chk({27'h0, loaded, oe}, 32'h0, "reload floats");
        wait_loaded();
        tk(8);
        chk({28'h0, txd_p, rts_p, rxd_c, cts_c}, 32'hA, "inversion cleared");
        done("reload");
        // line driver enable leads the start bit, drops with stop
        rdy <= 1'b1;
        tk(3);
        chk({30'h0, pin_lvl[0], go}, 32'h2, "enable before start");
        pulse(P_TICK);
        rdy <= 1'b0;
        tk(1);
        chk({31'h0, go}, 32'h1, "start bit released");
        pulse(P_STOP);
        tk(2);
        chk({31'h0, pin_lvl[0]}, 32'h0, "enable off at stop");
        done("line enable");
        // usb bus reset restarts the load
        pulse(P_RST);
        tk(2);
        chk({31'h0, loaded}, 32'h0, "bus reset clears");
        wait_loaded();
        done("bus reset");
        final_report();
    end
endmodule
